// *** common/sps_pkg.sv ***
// Types shared by the serial peripheral port design.
package sps_pkg;
    // Control register fields as software writes them.
    typedef struct packed {
        logic transfer_irq_enable;
        logic port_enable;
        logic master_select;
        logic clock_polarity;
        logic clock_phase;
        logic [2:0] bit_rate_select;
    } sps_ctrl_s;
    // Control/status register fields.
    typedef struct packed {
        logic transfer_done_flag;
        logic overrun;
        logic soft_select_manage;
        logic soft_select_level;
    } sps_csr_s;
    // Shift engine states.
    typedef enum logic [2:0] {
        SPS_IDLE = 3'b001,
        SPS_LEAD = 3'b010,
        SPS_TRAIL = 3'b100
    } sps_state_e;
endpackage

// *** common/sps_regs.svh ***
// Bit count, queue sizes and reset values for the serial peripheral port.
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_CTRL_RESET 8'h00
`define SPS_CSR_RESET 8'h00
`define SPS_DATA_RESET 8'h00
`define SPS_BITS_PER_BYTE 4'h8
`define SPS_FIFO_DEPTH 16
`define SPS_FIFO_WIDTH 8
`endif

// *** dv/sps_core_assertions.sv ***
// Concurrent checks on the serial peripheral port flags and pins.
`timescale 1ns/10ps
module sps_core_chk
    import sps_pkg::*;
(
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Reset, active low.
    input wire sps_ctrl_s ctrl, // Control contents.
    input wire sps_csr_s csr, // Status contents.
    input wire logic data_wr, // Data write strobe.
    input wire logic data_rd, // Data read strobe.
    input wire logic [7:0] data_rdata, // Received byte.
    input wire logic cpu_irq_mask, // CPU mask.
    input wire logic transfer_irq, // Interrupt level.
    input wire logic sck_out, // Serial clock out.
    input wire logic sck_oe_n, // Clock enable, low drives.
    input wire logic mosi_oe_n, // MOSI enable, low drives.
    input wire logic miso_oe_n, // MISO enable, low drives.
    input wire logic ss_n_in // Select pin.
);
    logic [7:0] gap;
    logic [8:0] half;
    logic sel_low;
    // Effective select and the shortest legal half period.
    assign sel_low = csr.soft_select_manage ? !csr.soft_select_level : !ss_n_in;
    assign half = 9'h002 << ctrl.bit_rate_select;
    // Cycles since the clock pin moved; saturates so long idles stay legal.
    always_ff @(posedge core_clk) begin
        if (!nrst || $changed(sck_out)) begin
            gap <= 8'h00;
        end else if (gap != 8'hFF) begin
            gap <= gap + 8'h01;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_irq_level: assert property (
        transfer_irq == (csr.transfer_done_flag && ctrl.transfer_irq_enable && !cpu_irq_mask))
        else $error("irq level disagrees with flag, enable and mask");
    a_flag_clear: assert property (
        $fell(csr.transfer_done_flag) |-> $past(data_rd) || $past(data_wr))
        else $error("done flag fell without a data access");
    a_sck_rate: assert property (
        $changed(sck_out) && !sck_oe_n && $stable(ctrl) |-> {1'b0, gap} + 9'h001 >= half)
        else $error("serial clock toggled faster than the rate");
    a_slave_sck: assert property (
        !sck_oe_n |-> ctrl.master_select || $past(ctrl.master_select))
        else $error("clock driven outside master mode");
    a_mosi_master: assert property (
        !mosi_oe_n |-> ctrl.master_select || $past(ctrl.master_select))
        else $error("MOSI driven outside master mode");
    a_miso_slave: assert property (
        !miso_oe_n |-> !ctrl.master_select || !$past(ctrl.master_select))
        else $error("MISO driven in master mode");
    a_sel_clear: assert property (
        (sel_low) [*5] |-> !ctrl.master_select)
        else $error("master bit kept while select low");
    a_rdata_flag: assert property (
        $changed(data_rdata) |-> ##[0:1] csr.transfer_done_flag)
        else $error("received byte changed without completion");
    a_overrun_cause: assert property (
        $rose(csr.overrun) |-> $past(csr.transfer_done_flag))
        else $error("overrun without a pending flag");
endmodule
bind sps_core sps_core_chk u_chk (.core_clk, .nrst, .ctrl, .csr, .data_wr, .data_rd,
    .data_rdata, .cpu_irq_mask, .transfer_irq, .sck_out, .sck_oe_n, .mosi_oe_n, .miso_oe_n,
    .ss_n_in);

// *** dv/sps_slave_model.sv ***
// Behavioural serial slave on the far side of the master port.
`timescale 1ns/10ps
module sps_slave_model (
    input wire logic sck, // Serial clock wire.
    input wire logic mosi, // Data from the master.
    input wire logic sel_n, // Select, active low.
    input wire logic [1:0] mode, // Polarity and phase.
    input wire logic [7:0] tx, // Byte to return.
    output logic miso, // Data to the master.
    output logic [7:0] rx // Last byte taken in.
);
    int b = 8;
    initial miso = 1'b0;
    initial rx = 8'h00;
    // Phase zero needs the first bit out before any clock edge.
    always @(negedge sel_n) begin
        b = mode[0] ? 0 : 1;
        miso = tx[7];
    end
    always @(sck) begin
        if (!sel_n && ((sck !== mode[1]) ^ mode[0])) begin
            rx = {rx[6:0], mosi};
        end else if (!sel_n && b < 8) begin
            miso = tx[7 - b];
            b = b + 1;
        end
    end
    // A released line shows the inverse, so a stale bit is never read as good.
    always @(posedge sel_n) begin
        miso = ~miso;
    end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the serial peripheral port.
`timescale 1ns/10ps
module tb_top
    import sps_pkg::*;
;
    logic core_clk = 1'b0, nrst = 1'b0, cpu_irq_mask = 1'b0, sel_n = 1'b1, ss_n = 1'b1;
    logic sck_m = 1'b0, mosi_m = 1'b0;
    logic [4:0] stb = 5'h00;
    logic [7:0] wdat = 8'h00, stx = 8'h00, rbuf = 8'h00, mb = 8'hA5;
    logic [1:0] mode = 2'b00;
    sps_ctrl_s ctrl;
    sps_csr_s csr;
    logic [7:0] data_rdata, srx;
    logic transfer_irq, tx_full, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic smiso;
    wire logic sck_w, mosi_w, miso_w;
    int err_total = 0, n_compared = 0;
    // Wire levels: the driving party wins; an undriven clock sits at its pulled level.
    assign sck_w = sck_oe_n ? sck_m : sck_out;
    assign mosi_w = mosi_oe_n ? mosi_m : mosi_out;
    assign miso_w = miso_oe_n ? smiso : miso_out;
    sps_core u_dut (.core_clk, .nrst, .ctrl_wr(stb[0]), .ctrl_wdata(wdat), .ctrl,
        .csr_wr(stb[1]), .csr_rd(stb[2]), .csr_wdata(wdat[1:0]), .csr, .data_wr(stb[3]),
        .data_rd(stb[4]), .data_wdata(wdat), .data_rdata, .cpu_irq_mask, .transfer_irq,
        .tx_full, .sck_in(sck_w), .sck_out, .sck_oe_n, .mosi_in(mosi_w), .mosi_out,
        .mosi_oe_n, .miso_in(miso_w), .miso_out, .miso_oe_n, .ss_n_in(ss_n));
    sps_slave_model u_peer (.sck(sck_w), .mosi(mosi_w), .sel_n, .mode, .tx(stx),
        .miso(smiso), .rx(srx));
    // Core clock, 4 ns period.
    initial forever #2 core_clk = ~core_clk;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // One strobe for one cycle: 0 ctrl write, 1 csr write, 2 csr read, 3 data write, 4 data read.
    task automatic acc(input int k, input logic [7:0] v);
        @(posedge core_clk);
        stb <= 5'h01 << k;
        wdat <= v;
        @(posedge core_clk);
        stb <= 5'h00;
    endtask
    task automatic wait_flag;
        for (int i = 0; i < 4000 && csr.transfer_done_flag !== 1'b1; i++)
            @(posedge core_clk);
        #1;
        chk(csr.transfer_done_flag, 1'b1);
    endtask
    task automatic clr;
        acc(2, 8'h00);
        acc(4, 8'h00);
        #1;
        chk(csr.transfer_done_flag, 1'b0);
    endtask
    task automatic rst;
        nrst <= 1'b0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
    endtask
    task automatic mset(input logic [1:0] m, input logic [2:0] r, input logic ie);
        mode = m;
        sck_m <= m[1];
        acc(0, {3'b000, m, r});
        acc(1, 8'h03);
        acc(0, {ie, 2'b11, m, r});
        #1;
        chk(ctrl.master_select, 1'b1);
    endtask
    task automatic mx(input logic [7:0] b, input logic [7:0] s);
        stx = s;
        sel_n = 1'b0;
        acc(3, b);
        wait_flag;
        sel_n = 1'b1;
        chk(srx, b);
        chk(data_rdata, s);
    endtask
    task automatic finish_test;
        $display("compared=%0d errors=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence: master modes, refusals, select loss, slave byte, queue fill.
    initial begin
        rst;
        for (int m = 0; m < 4; m++) begin
            mset(m[1:0], m[0] ? 3'h2 : 3'h1, 1'b1);
            mx(8'hA5 ^ m[7:0], 8'h3C + m[7:0]);
            chk(transfer_irq, 1'b1);
            clr;
        end
        cpu_irq_mask <= 1'b1;
        mx(8'h81, 8'h7E);
        chk(transfer_irq, 1'b0);
        acc(3, 8'hFF);
        acc(4, 8'h00);
        #1;
        chk(csr.transfer_done_flag, 1'b1);
        clr;
        repeat (200) @(posedge core_clk);
        chk(csr.transfer_done_flag, 1'b0);
        acc(2, 8'h00);
        mx(8'h33, 8'h22);
        acc(2, 8'h00);
        acc(3, 8'h44);
        for (int i = 0; i < 400 && csr.overrun !== 1'b1; i++)
            @(posedge core_clk);
        chk(csr.overrun, 1'b1);
        rst;
        #1;
        chk({ctrl, csr}, 12'h000);
        mset(2'b00, 3'h1, 1'b0);
        acc(1, 8'h00);
        ss_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        chk({ctrl.master_select, ctrl.port_enable}, 2'b00);
        ss_n <= 1'b1;
        acc(0, 8'h40);
        acc(3, 8'h3C);
        #1;
        chk(csr.transfer_done_flag, 1'b0);
        chk(sck_oe_n, 1'b1);
        ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi_m = mb[i];
            #16 sck_m = 1'b1;
            rbuf = {rbuf[6:0], miso_w};
            #16 sck_m = 1'b0;
        end
        #16 ss_n = 1'b1;
        wait_flag;
        chk(rbuf, 8'h3C);
        chk(data_rdata, 8'hA5);
        acc(2, 8'h00);
        acc(3, 8'h00);
        #1;
        chk(csr.transfer_done_flag, 1'b0);
        mset(2'b01, 3'h1, 1'b0);
        sel_n = 1'b0;
        for (int j = 0; j < 18; j++)
            acc(3, 8'h10 + j[7:0]);
        #1;
        chk(tx_full, 1'b1);
        for (int j = 0; j < 17; j++) begin
            wait_flag;
            clr;
        end
        chk({tx_full, srx}, 9'h01F);
        finish_test;
    end
    // Watchdog well past the expected run of some ten microseconds.
    initial begin
        #100000;
        err_total++;
        finish_test;
    end
endmodule

// *** rtl/sps_core.sv ***
// Serial peripheral port: master/slave byte shifter with two-step flag clear.
//
// Function
// - Master drives SCK with rate, polarity and phase from control bits.
// - In master mode, master-select and port enable are forced clear while select is low.
// - Master data write loads shifter, MOSI sends MSB first.
// - Byte end sets done flag; interrupt if enabled and CPU unmasked.
// - Master clears done flag by status access then data read.
// - Data writes ignored while flag set until status is read or written.
// - Slave takes serial clock from SCK pin, never generates it.
// - Slave data write loads shifter, MISO sends MSB first.
// - Slave transfer starts on select with a byte queued, MSB first on MOSI.
// - Slave clears flag by status access then data read or write.
`timescale 1ns/10ps
`include "sps_regs.svh"
module sps_core
    import sps_pkg::*;
(
    input wire logic core_clk, // Core clock, 250 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic ctrl_wr, // Control register write strobe.
    input wire logic [7:0] ctrl_wdata, // Control register write data.
    output sps_ctrl_s ctrl, // Control register contents.
    input wire logic csr_wr, // Control/status write strobe.
    input wire logic csr_rd, // Control/status read strobe.
    input wire logic [1:0] csr_wdata, // Soft select manage and level.
    output sps_csr_s csr, // Control/status contents.
    input wire logic data_wr, // Data register write strobe.
    input wire logic data_rd, // Data register read strobe.
    input wire logic [7:0] data_wdata, // Byte to send.
    output logic [7:0] data_rdata, // Last received byte.
    input wire logic cpu_irq_mask, // CPU condition code interrupt mask.
    output logic transfer_irq, // Interrupt request level.
    output logic tx_full, // Transmit queue cannot accept a byte.
    input wire logic sck_in, // SCK pin input.
    output logic sck_out, // SCK pin output.
    output logic sck_oe_n, // SCK enable, low while driving.
    input wire logic mosi_in, // MOSI pin input.
    output logic mosi_out, // MOSI pin output.
    output logic mosi_oe_n, // MOSI enable, low while driving.
    input wire logic miso_in, // MISO pin input.
    output logic miso_out, // MISO pin output.
    output logic miso_oe_n, // MISO enable, low while driving.
    input wire logic ss_n_in // Slave select pin, active low.
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second.
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sck_prev;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sck_prev <= 1'b1;
        end else begin
            sync1 <= {ss_n_in, sck_in, mosi_in | miso_in & 1'b0};
            sync2 <= sync1;
            sck_prev <= sync2[1];
        end
    end
    // MISO is needed separately in master mode; keep it in its own pair.
    logic miso_s1;
    logic miso_s2;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= miso_in;
            miso_s2 <= miso_s1;
        end
    end
    wire ss_pin_n = sync2[2];
    wire sck_pin = sync2[1];
    wire mosi_pin = sync2[0];

    ////////////////////////////////////////////////////////////////////////
    // Effective select: soft level when managed by software, else the pin.
    wire sel_high = csr.soft_select_manage ? csr.soft_select_level : ss_pin_n;
    wire is_master = ctrl.master_select && ctrl.port_enable;
    wire is_slave = !ctrl.master_select && ctrl.port_enable;
    wire slave_sel = is_slave && !sel_high;
    sps_state_e state;
    wire busy = (state != SPS_IDLE);

    // Rate divider: half bit period of 2^(rate+1) core clocks.
    logic [8:0] div_cnt;
    wire [8:0] div_top = 9'((9'h2 << ctrl.bit_rate_select) - 9'h1);
    wire half_tick = is_master && busy && (div_cnt == div_top);
    always_ff @(posedge core_clk) begin
        if (!nrst || !busy || half_tick) begin
            div_cnt <= 9'h000;
        end else begin
            div_cnt <= div_cnt + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge sources: divider ticks in master, sampled SCK edges in slave.
    wire sck_edge = slave_sel && (sck_pin != sck_prev);
    wire edge_evt = half_tick || sck_edge;

    // Control register with select forcing.
    // select low in master mode clears mode
    wire force_clr = is_master && !sel_high;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl <= sps_ctrl_s'(`SPS_CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl <= sps_ctrl_s'(ctrl_wdata);
        end else if (force_clr) begin
            ctrl.master_select <= 1'b0;
            ctrl.port_enable <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-step clear: status access arms, data read (or data write in slave mode) finishes.
    logic armed;
    logic [7:0] shifter;
    logic [3:0] bit_cnt;
    logic rx_bit;
    logic done_evt;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire csr_access = csr_rd || csr_wr;
    wire clr_req = armed && (data_rd || (!ctrl.master_select && data_wr));
    wire wr_ok = data_wr && !(csr.transfer_done_flag && !armed);
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (csr_access && csr.transfer_done_flag) begin
            armed <= 1'b1;
        end else if (clr_req || !csr.transfer_done_flag) begin
            armed <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            csr <= sps_csr_s'(`SPS_CSR_RESET);
        end else begin
            if (csr_wr) begin
                csr.soft_select_manage <= csr_wdata[1];
                csr.soft_select_level <= csr_wdata[0];
            end
            if (done_evt) begin
                csr.transfer_done_flag <= 1'b1;
                csr.overrun <= csr.transfer_done_flag && !clr_req;
            end else if (clr_req) begin
                csr.transfer_done_flag <= 1'b0;
                csr.overrun <= 1'b0;
            end
        end
    end
    assign transfer_irq = csr.transfer_done_flag && ctrl.transfer_irq_enable && !cpu_irq_mask;

    ////////////////////////////////////////////////////////////////////////
    // Shift engine. Leading edge samples, trailing edge shifts the next bit.
    // Phase 1 defers the first sample by one edge.
    wire start_ok = fifo_out_valid && (is_master || slave_sel) && !busy;
    wire sample_edge = (state == SPS_LEAD);
    wire rx_in = ctrl.master_select ? miso_s2 : mosi_pin;
    logic phase_skip;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= SPS_IDLE;
            shifter <= `SPS_DATA_RESET;
            bit_cnt <= 4'h0;
            rx_bit <= 1'b0;
            phase_skip <= 1'b0;
            done_evt <= 1'b0;
            data_rdata <= `SPS_DATA_RESET;
        end else begin
            done_evt <= 1'b0;
            case (state)
                SPS_IDLE: begin
                    if (start_ok) begin
                        shifter <= fifo_out_data;
                        bit_cnt <= 4'h0;
                        phase_skip <= ctrl.clock_phase;
                        state <= SPS_LEAD;
                    end
                end
                SPS_LEAD: begin
                    if (edge_evt) begin
                        if (phase_skip) begin
                            phase_skip <= 1'b0;
                        end else begin
                            rx_bit <= rx_in;
                            state <= SPS_TRAIL;
                        end
                    end
                end
                SPS_TRAIL: begin
                    // Phase 1 has no clock edge after the last sample, so the final
                    // shift follows at once rather than adding a seventeenth edge.
                    if (edge_evt || (ctrl.clock_phase && bit_cnt == 4'h7)) begin
                        shifter <= {shifter[6:0], rx_bit};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `SPS_BITS_PER_BYTE - 4'h1) begin
                            data_rdata <= {shifter[6:0], rx_bit};
                            done_evt <= 1'b1;
                            state <= SPS_IDLE;
                        end else begin
                            state <= SPS_LEAD;
                        end
                    end
                end
                default: begin
                    state <= SPS_IDLE;
                end
            endcase
            if (slave_sel == 1'b0 && !is_master && busy) begin
                state <= SPS_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial clock: idles at polarity, toggles with each half tick.
    // master clock generation
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sck_out <= 1'b0;
        end else if (!busy) begin
            sck_out <= ctrl.clock_polarity;
        end else if (half_tick) begin
            sck_out <= !sck_out;
        end
    end
    assign sck_oe_n = !is_master;
    assign mosi_out = shifter[7];
    assign mosi_oe_n = !is_master;
    assign miso_out = shifter[7];
    assign miso_oe_n = !slave_sel;

    // Transmit queue; a write is taken only when room remains.
    wire fifo_in_ready;
    assign tx_full = !fifo_in_ready;
    sps_fifo #(
        .WIDTH(`SPS_FIFO_WIDTH),
        .DEPTH(`SPS_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(wr_ok && ctrl.port_enable),
        .in_ready(fifo_in_ready),
        .in_data(data_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(start_ok),
        .out_data(fifo_out_data)
    );
endmodule

// *** rtl/sps_fifo.sv ***
// Small valid/ready FIFO holding bytes queued for transmission.
`timescale 1ns/10ps
module sps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic in_valid, // Write side offers a word.
    output logic in_ready, // Room for a word.
    input wire logic [WIDTH-1:0] in_data, // Word written.
    output logic out_valid, // A word is waiting.
    input wire logic out_ready, // Drain side takes the word.
    output logic [WIDTH-1:0] out_data // Oldest word, read combinationally from storage.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Honest full and empty taken from the occupancy count.
    assign in_ready = (count != (AW + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    ////////////////////////////////////////////////////////////////////////
    // Pointers and storage; data is written into registers, read out of them.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule
